// >>> ssp_core.sv
module ssp_core (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire ssp_pkg::ssp_bus_t bus,
    output logic [31:0] rd_data,
    input wire logic serial_clock_line_in,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe,
    input wire logic frame_select_line_in,
    output logic frame_select_line_out,
    output logic frame_select_line_oe,
    output logic serial_out_line_out,
    output logic serial_out_line_oe,
    input wire logic serial_in_line
);
    import ssp_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [1:0] sck_q, fss_q, sin_q;
    logic sck_p_q, fss_p_q;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sck_q <= 2'h0;
            fss_q <= 2'h3;
            sin_q <= 2'h0;
            sck_p_q <= 1'b0;
            fss_p_q <= 1'b1;
        end else if (ce) begin
            sck_q <= {sck_q[0], serial_clock_line_in};
            fss_q <= {fss_q[0], frame_select_line_in};
            sin_q <= {sin_q[0], serial_in_line};
            sck_p_q <= sck_q[1];
            fss_p_q <= fss_q[1];
        end
    end

    // ----------------------------------------
    // Registers and FIFOs
    // ----------------------------------------
    ssp_cfg_t cfg_q, cfg_d;
    logic [7:0] div_q, div_d;
    logic [31:0] rd_data_q, rd_data_d;
    logic [SSP_DW-1:0] tx_mem_q [SSP_DEPTH];
    logic [SSP_DW-1:0] rx_mem_q [SSP_DEPTH];
    logic [SSP_PW-1:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic [SSP_PW:0] tx_cnt_q, rx_cnt_q, tx_cnt_d, rx_cnt_d;
    logic tx_push, tx_pop, rx_push, rx_pop, tx_any;
    logic [SSP_DW-1:0] tx_head, rx_val;
    ssp_st_t st_q;

    assign tx_head = tx_mem_q[tx_rp_q];
    assign tx_any = tx_cnt_q != '0;
    assign tx_push = bus.wr && bus.addr == SSP_A_DATA && !tx_cnt_q[SSP_PW];
    assign rx_pop = bus.rd && bus.addr == SSP_A_DATA && rx_cnt_q != '0;

    always_comb begin
        cfg_d = cfg_q;
        div_d = div_q;
        rd_data_d = 32'h0;
        tx_cnt_d = tx_cnt_q + (SSP_PW+1)'(tx_push) - (SSP_PW+1)'(tx_pop);
        rx_cnt_d = rx_cnt_q + (SSP_PW+1)'(rx_push && !rx_cnt_q[SSP_PW])
            - (SSP_PW+1)'(rx_pop);
        if (bus.wr && bus.addr == SSP_A_CTRL) begin
            cfg_d = bus.wdata[$bits(ssp_cfg_t)-1:0];
        end
        if (bus.wr && bus.addr == SSP_A_DIV) begin
            div_d = bus.wdata[7:0];
        end
        if (bus.rd) begin
            case (bus.addr)
                SSP_A_CTRL: rd_data_d = 32'(cfg_q);
                SSP_A_DIV: rd_data_d = {24'h0, div_q};
                SSP_A_DATA: rd_data_d = rx_pop ? {16'h0, rx_mem_q[rx_rp_q]} : 32'h0;
                SSP_A_STAT: rd_data_d = {27'h0, rx_cnt_q[SSP_PW], rx_cnt_q != '0,
                    tx_cnt_q[SSP_PW], !tx_any, st_q == SSP_RUN};
                default: rd_data_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cfg_q <= SSP_CFG_RST;
            div_q <= SSP_DIV_RST;
            rd_data_q <= 32'h0;
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            tx_cnt_q <= '0;
            rx_cnt_q <= '0;
        end else if (ce) begin
            cfg_q <= cfg_d;
            div_q <= div_d;
            rd_data_q <= rd_data_d;
            tx_cnt_q <= tx_cnt_d;
            rx_cnt_q <= rx_cnt_d;
            tx_wp_q <= tx_wp_q + SSP_PW'(tx_push);
            tx_rp_q <= tx_rp_q + SSP_PW'(tx_pop);
            rx_wp_q <= rx_wp_q + SSP_PW'(rx_push && !rx_cnt_q[SSP_PW]);
            rx_rp_q <= rx_rp_q + SSP_PW'(rx_pop);
        end
    end

    // Memories carry no reset; only the pointers define what is valid
    always_ff @(posedge mclk) begin
        if (ce && tx_push) begin
            tx_mem_q[tx_wp_q] <= bus.wdata[SSP_DW-1:0];
        end
        if (ce && rx_push && !rx_cnt_q[SSP_PW]) begin
            rx_mem_q[rx_wp_q] <= rx_val;
        end
    end
    assign rd_data = rd_data_q;

    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    logic [7:0] hcnt_q, hcnt_d;
    logic [5:0] k_q, k_d, kn, nn2, lastk;
    logic [4:0] n, sc_q, sc_d;
    logic [SSP_DW-1:0] txsh_q, txsh_d, rxsh_q, rxsh_d, algn;
    logic fs_q, fs_d, sclk_q, sclk_d, sdo_q, sdo_d, sdo_oe_q, sdo_oe_d;
    logic sclk_oe_q, cap_q, cap_d, ld_q, ld_d, act, tick;
    logic rise, fall, lead, trail, cap_e, lau_e, cspo, csph, idle_lvl;
    ssp_st_t st_d;

    always_comb begin
        n = {1'b0, (cfg_q.size_m1 < SSP_SIZE_MIN) ? SSP_SIZE_MIN : cfg_q.size_m1} + 5'h1;
        nn2 = {n, 1'b0};
        lastk = SSP_CW_REPLY + {n, 1'b0};
        // MSB first: the word is parked at the top of the shifter
        algn = tx_head << (5'h10 - n);
        idle_lvl = cfg_q.clock_polarity_bit && !cfg_q.cw;
        cspo = cfg_q.clock_polarity_bit && !cfg_q.cw;
        csph = cfg_q.clock_phase_bit && !cfg_q.cw;
        rise = sck_q[1] && !sck_p_q;
        fall = !sck_q[1] && sck_p_q;
        lead = cspo ? fall : rise;
        trail = cspo ? rise : fall;
        cap_e = csph ? trail : lead;
        lau_e = csph ? lead : trail;
        tick = hcnt_q == 8'h0;
        kn = k_q + 6'h1;
        hcnt_d = tick ? div_q : hcnt_q - 8'h1;
        st_d = st_q;
        k_d = k_q;
        sc_d = sc_q;
        ld_d = ld_q;
        txsh_d = txsh_q;
        rxsh_d = rxsh_q;
        fs_d = fs_q;
        sclk_d = sclk_q;
        sdo_d = sdo_q;
        cap_d = 1'b0;
        act = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_val = rxsh_q & ~(16'hffff << n);
        if (cfg_q.master) begin
            if (st_q == SSP_IDLE) begin
                fs_d = 1'b1;
                sdo_d = 1'b0;
                sclk_d = idle_lvl;
                if (tick && cfg_q.en && tx_any) begin
                    st_d = SSP_RUN;
                    fs_d = 1'b0;
                    k_d = 6'h0;
                    tx_pop = 1'b1;
                    if (cfg_q.cw) begin
                        sdo_d = tx_head[7];
                        txsh_d = {tx_head[6:0], 9'h0};
                    end else begin
                        txsh_d = algn;
                    end
                end
            end else if (tick) begin
                k_d = kn;
                if (!cfg_q.cw) begin
                    act = cfg_q.clock_phase_bit ? (kn[0] && kn < nn2)
                        : (!kn[0] && kn >= 6'h2 && kn <= nn2);
                    sclk_d = cfg_q.clock_polarity_bit ^ act;
                    if (kn[0] && kn < nn2) begin
                        sdo_d = txsh_q[15];
                        txsh_d = txsh_q << 1;
                    end
                    if (!kn[0] && kn >= 6'h2 && kn <= nn2) begin
                        rxsh_d = {rxsh_q[14:0], sin_q[1]};
                        cap_d = 1'b1;
                    end
                    if (cfg_q.clock_phase_bit && kn == nn2 + 6'h1 && cfg_q.en && tx_any) begin
                        rx_push = 1'b1;
                        tx_pop = 1'b1;
                        sdo_d = algn[15];
                        txsh_d = algn << 1;
                        sclk_d = !cfg_q.clock_polarity_bit;
                        k_d = 6'h1;
                    end else if (kn == nn2 + 6'h2) begin
                        // Phase 0 runs return through idle, so select pulses high
                        rx_push = 1'b1;
                        st_d = SSP_IDLE;
                        fs_d = 1'b1;
                        sdo_d = 1'b0;
                        sclk_d = idle_lvl;
                    end
                end else begin
                    sclk_d = kn[0] && kn <= lastk;
                    if (!kn[0] && kn <= SSP_CW_LAST) begin
                        sdo_d = txsh_q[15];
                        txsh_d = txsh_q << 1;
                    end
                    if (kn == SSP_CW_QUIET) begin
                        sdo_d = 1'b0;
                    end
                    if (kn[0] && kn >= SSP_CW_FIRST && kn <= lastk) begin
                        rxsh_d = {rxsh_q[14:0], sin_q[1]};
                        cap_d = 1'b1;
                    end
                    if (kn == lastk + 6'h1 && cfg_q.en && tx_any) begin
                        rx_push = 1'b1;
                        tx_pop = 1'b1;
                        sdo_d = tx_head[7];
                        txsh_d = {tx_head[6:0], 9'h0};
                        k_d = 6'h0;
                    end else if (kn == lastk + 6'h2) begin
                        rx_push = 1'b1;
                        st_d = SSP_IDLE;
                        fs_d = 1'b1;
                        sdo_d = 1'b0;
                    end
                end
            end
        end else begin
            fs_d = 1'b1;
            sclk_d = cspo;
            if (fss_q[1]) begin
                st_d = SSP_IDLE;
                sdo_d = 1'b0;
            end else if (fss_p_q) begin
                // Select just fell: fresh word, zeros if nothing queued
                st_d = SSP_RUN;
                sc_d = 5'h0;
                rxsh_d = 16'h0;
                ld_d = !csph;
                if (!csph) begin
                    tx_pop = tx_any;
                    sdo_d = tx_any && algn[15];
                    txsh_d = tx_any ? algn << 1 : 16'h0;
                end
            end else begin
                if (lau_e && ld_q) begin
                    sdo_d = txsh_q[15];
                    txsh_d = txsh_q << 1;
                end else if (lau_e && csph) begin
                    ld_d = 1'b1;
                    tx_pop = tx_any;
                    sdo_d = tx_any && algn[15];
                    txsh_d = tx_any ? algn << 1 : 16'h0;
                end
                if (cap_e) begin
                    rxsh_d = {rxsh_q[14:0], sin_q[1]};
                    cap_d = 1'b1;
                    sc_d = sc_q + 5'h1;
                    if (sc_q == n - 5'h1) begin
                        rx_val = {rxsh_q[14:0], sin_q[1]} & ~(16'hffff << n);
                        rx_push = 1'b1;
                        sc_d = 5'h0;
                        ld_d = 1'b0;
                    end
                end
            end
        end
        sdo_oe_d = cfg_q.master ? !fs_d : !fss_q[1];
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= SSP_IDLE;
            hcnt_q <= 8'h0;
            k_q <= 6'h0;
            sc_q <= 5'h0;
            ld_q <= 1'b0;
            txsh_q <= 16'h0;
            rxsh_q <= 16'h0;
            fs_q <= 1'b1;
            sclk_q <= 1'b0;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            sclk_oe_q <= 1'b1;
            cap_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            hcnt_q <= hcnt_d;
            k_q <= k_d;
            sc_q <= sc_d;
            ld_q <= ld_d;
            txsh_q <= txsh_d;
            rxsh_q <= rxsh_d;
            fs_q <= fs_d;
            sclk_q <= sclk_d;
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
            sclk_oe_q <= cfg_q.master;
            cap_q <= cap_d;
        end
    end

    assign serial_clock_line_out = sclk_q;
    assign serial_clock_line_oe = sclk_oe_q;
    assign frame_select_line_out = fs_q;
    assign frame_select_line_oe = sclk_oe_q;
    assign serial_out_line_out = sdo_q;
    assign serial_out_line_oe = sdo_oe_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_idle_levels: assert property ((st_q == SSP_IDLE && cfg_q.master)
        |-> fs_q && !sdo_q)
        else $error("idle master not quiet");
    a_pad_enable: assert property (ce |=> sclk_oe_q == $past(cfg_q.master))
        else $error("clock pad enable wrong");
    a_start_cond: assert property ((cfg_q.master && $fell(fs_q))
        |-> $past(tx_any) && $past(cfg_q.en))
        else $error("frame began without data or enable");
    a_out_pad: assert property (cfg_q.master |-> sdo_oe_q == !fs_q)
        else $error("data pad enable not tied to select");
    a_cap_level: assert property ((cfg_q.master && !cfg_q.cw && cap_q)
        |-> sclk_q == (cfg_q.clock_polarity_bit ^ !cfg_q.clock_phase_bit))
        else $error("capture on wrong clock edge");
    a_frame_low: assert property ((st_q == SSP_RUN && cfg_q.master) |-> !fs_q)
        else $error("select high inside frame");
    a_cw_quiet: assert property ((cfg_q.master && cfg_q.cw && cap_q)
        |-> k_q >= SSP_CW_FIRST && k_q[0] && sclk_q)
        else $error("reply latched during control word");
    a_cw_msb: assert property ((cfg_q.master && cfg_q.cw && $fell(fs_q))
        |-> sdo_q == $past(tx_head[7]))
        else $error("control MSB not on line at select fall");
endmodule

// >>> ssp_pkg.sv
package ssp_pkg;
// ----------------------------------------
// Summary of operation
// - Idle: select high, data low, clock parked
// - Master drives clock pad, slave takes clock
// - Master starts only when enabled with queued data
// - Mode 00: data, half period, rising capture
// - Phase 0: select pulses high between words
// - Select rises one period after last capture
// - Mode 01: first edge rising, falling capture
// - Phase 1: select stays low between words
// - Mode 10: clock idles high, falling capture
// - Mode 11: first edge falling, rising capture
// - Control format: 8-bit word, n-bit reply received
// - Select fall loads word, drives its MSB
// - Control latched rising, reply latched rising
// - Select rises one period after reply, stores it
// - Continuous: next control byte follows at once
// - Continuous: reply stored on next falling edge
// - Slave samples on rising edges in modes 00, 11 and control format; falling in 01, 10
// - Frames MSB first, 4 to 16 bits
// ----------------------------------------
localparam int SSP_AW = 8;
localparam int SSP_DW = 16;
localparam int SSP_DEPTH = 8;
localparam int SSP_PW = 3;
localparam logic [SSP_AW-1:0] SSP_A_CTRL = 8'h00;
localparam logic [SSP_AW-1:0] SSP_A_DIV = 8'h04;
localparam logic [SSP_AW-1:0] SSP_A_DATA = 8'h08;
localparam logic [SSP_AW-1:0] SSP_A_STAT = 8'h0c;
localparam logic [3:0] SSP_SIZE_MIN = 4'h3;
localparam logic [5:0] SSP_CW_LAST = 6'h0e;
localparam logic [5:0] SSP_CW_QUIET = 6'h10;
localparam logic [5:0] SSP_CW_REPLY = 6'h11;
localparam logic [5:0] SSP_CW_FIRST = 6'h13;
localparam logic [7:0] SSP_DIV_RST = 8'h03;
typedef struct packed {
    logic [3:0] size_m1;
    logic cw;
    logic clock_phase_bit;
    logic clock_polarity_bit;
    logic master;
    logic en;
} ssp_cfg_t;
localparam ssp_cfg_t SSP_CFG_RST = '{size_m1: 4'h7, cw: 1'b0, clock_phase_bit: 1'b0,
    clock_polarity_bit: 1'b0, master: 1'b1, en: 1'b0};
typedef struct packed {
    logic [SSP_AW-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
} ssp_bus_t;
typedef enum logic {SSP_IDLE, SSP_RUN} ssp_st_t;
endpackage

// >>> ssp_peer.sv
module ssp_peer (
    input wire logic sck,
    input wire logic fs,
    input wire logic mosi,
    input wire logic clock_polarity_bit,
    input wire logic clock_phase_bit,
    input wire logic cw,
    input wire logic [4:0] nbits,
    output logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] sh = 16'h0;
    logic [15:0] acc = 16'h0;
    logic drv = 1'b0;
    int c = 0;
    logic [15:0] txq[$];
    logic [15:0] rxq[$];

    // ----------------------------------------
    // Released line
    // ----------------------------------------
    // Shows the inverse of the bit, so a stale sample never passes by luck
    assign miso = sh[nbits-1] ^ (fs | (cw & ~drv));

    function automatic logic [15:0] nxt();
        return (txq.size() > 0) ? txq.pop_front() : 16'h0;
    endfunction

    always @(negedge fs) begin
        c = 0;
        acc = 16'h0;
        drv = 1'b0;
        if (!clock_phase_bit || cw) sh = nxt();
    end

    // ----------------------------------------
    // Shifting
    // ----------------------------------------
    always @(sck) begin
        if (fs === 1'b0 && cw) begin
            if (sck) begin
                c++;
                if (c <= 8) acc = {acc[14:0], mosi};
                // Fresh byte per frame, or a continuous run would merge them
                if (c == 8) begin
                    rxq.push_back(acc);
                    acc = 16'h0;
                end
                if (c == 9 + nbits) c = 0;
            end else if (c >= 9) begin
                // Reply starts one clock after the control byte
                if (drv) sh = sh << 1;
                drv = 1'b1;
            end else if (drv) begin
                drv = 1'b0;
                sh = nxt();
            end
        end else if (fs === 1'b0) begin
            if (sck == (clock_polarity_bit == clock_phase_bit)) begin
                acc = {acc[14:0], mosi};
                c++;
                if (c == nbits) begin
                    rxq.push_back(acc);
                    c = 0;
                    acc = 16'h0;
                end
            end else if (c == 0) begin
                if (clock_phase_bit) sh = nxt();
            end else begin
                sh = sh << 1;
            end
        end
    end
endmodule

// >>> ssp_core_tb.sv
module ssp_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ssp_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic ce_en = 1'b1;
    ssp_bus_t bus = '0;
    logic [31:0] rd_data;
    logic sck_out, sck_oe, fs_out, fs_oe, sdo_out, sdo_oe, miso;
    logic sck_tb = 1'b0;
    logic fs_tb = 1'b1;
    logic clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0, cw = 1'b0;
    logic [4:0] nb = 5'h08;
    int miscompares = 0;
    int checks_done = 0;
    int fs_rises = 0;
    logic fs_prev = 1'b1;
    wire sck_w = sck_oe ? sck_out : sck_tb;
    wire fs_w = fs_oe ? fs_out : fs_tb;
    // Undriven data line toggles so it never looks like a held bit
    wire sdo_w = sdo_oe ? sdo_out : mclk;

    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        fs_prev <= fs_w;
        if (fs_w && !fs_prev) fs_rises <= fs_rises + 1;
    end

    ssp_core dut_u (
        .mclk(mclk), .rst_b(rst_b), .ce(ce_en), .bus(bus), .rd_data(rd_data),
        .serial_clock_line_in(sck_w), .serial_clock_line_out(sck_out),
        .serial_clock_line_oe(sck_oe), .frame_select_line_in(fs_w),
        .frame_select_line_out(fs_out), .frame_select_line_oe(fs_oe),
        .serial_out_line_out(sdo_out), .serial_out_line_oe(sdo_oe), .serial_in_line(miso)
    );
    ssp_peer peer_u (
        .sck(sck_w), .fs(fs_w), .mosi(sdo_w), .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit), .cw(cw),
        .nbits(nb), .miso(miso)
    );

    // ----------------------------------------
    // Bench tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(negedge mclk);
        d = rd_data;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        check(d, exp);
    endtask
    task automatic wait_idle();
        logic [31:0] d;
        for (int i = 0; i < 400; i++) begin
            rd(SSP_A_STAT, d);
            if (d[0] === 1'b0 && d[1] === 1'b1) return;
        end
        miscompares++;
        stop_test();
    endtask
    function automatic logic [31:0] cfg(input logic [4:0] n, input logic c, h, p, m, e);
        ssp_cfg_t v;
        v = '{size_m1: 4'(n - 5'h01), cw: c, clock_phase_bit: h, clock_polarity_bit: p, master: m, en: e};
        return {23'h0, v};
    endfunction
    function automatic logic [31:0] peer_got();
        if (peer_u.rxq.size() == 0) return 'x;
        return {16'h0, peer_u.rxq.pop_front()};
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] tx[2];
        logic [15:0] pw[2];
        logic [15:0] mask;
        int n0;
        repeat (4) @(posedge mclk);
        check({sck_out, sck_oe, fs_out, fs_oe, sdo_oe, sdo_out}, 32'h1c);
        rst_b <= 1'b1;
        rd_chk(SSP_A_CTRL, 32'h0e2);
        rd_chk(SSP_A_DIV, 32'h3);
        rd_chk(SSP_A_STAT, 32'h2);
        rd_chk(8'h10, 32'h0);
        rd_chk(SSP_A_DATA, 32'h0);
        // A write while the clock enable is low must not land
        ce_en <= 1'b0;
        wr(SSP_A_DIV, 32'h0000_0055);
        ce_en <= 1'b1;
        rd_chk(SSP_A_DIV, 32'h3);
        // Sizes 4, 8, 12, 16 across the four clock modes, two words each
        for (int m = 0; m < 4; m++) begin
            {clock_polarity_bit, clock_phase_bit} = 2'(m);
            nb = 5'(4 + 4 * m);
            mask = 16'((32'h1 << nb) - 32'h1);
            tx = '{16'h9a5c ^ 16'(m), 16'h36e1};
            pw = '{16'hc3a7, 16'h5e19 ^ 16'(m)};
            wr(SSP_A_CTRL, cfg(nb, 1'b0, clock_phase_bit, clock_polarity_bit, 1'b1, 1'b0));
            peer_u.rxq.delete();
            peer_u.txq = '{pw[0], pw[1]};
            wr(SSP_A_DATA, {16'h0, tx[0]});
            wr(SSP_A_DATA, {16'h0, tx[1]});
            repeat (40) @(posedge mclk);
            check({fs_out, sck_out, sdo_out}, {29'h0, 1'b1, clock_polarity_bit, 1'b0});
            n0 = fs_rises;
            wr(SSP_A_CTRL, cfg(nb, 1'b0, clock_phase_bit, clock_polarity_bit, 1'b1, 1'b1));
            wait_idle();
            check(32'(fs_rises - n0), clock_phase_bit ? 32'h1 : 32'h2);
            for (int w = 0; w < 2; w++) begin
                check(peer_got(), {16'h0, tx[w] & mask});
                rd_chk(SSP_A_DATA, {16'h0, pw[w] & mask});
            end
        end
        // Two control-word frames back to back
        nb = 5'h0c;
        cw = 1'b1;
        {clock_polarity_bit, clock_phase_bit} = 2'b00;
        peer_u.rxq.delete();
        peer_u.txq = '{16'h0b4d, 16'h0672};
        wr(SSP_A_CTRL, cfg(nb, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
        wr(SSP_A_DATA, 32'h0000_a5c5);
        wr(SSP_A_DATA, 32'h0000_003a);
        n0 = fs_rises;
        wr(SSP_A_CTRL, cfg(nb, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1));
        wait_idle();
        check(32'(fs_rises - n0), 32'h1);
        check(peer_got(), 32'hc5);
        check(peer_got(), 32'h3a);
        rd_chk(SSP_A_DATA, 32'h0b4d);
        rd_chk(SSP_A_DATA, 32'h0672);
        // Slave in modes 00 and 11, then control-word slave; clock made here at 125 ns
        cw = 1'b0;
        nb = 5'h08;
        for (int m = 0; m < 3; m++) begin
            // Control-word slave keeps mode 00 edges whatever the mode bits say
            {clock_polarity_bit, clock_phase_bit} = (m == 1) ? 2'b11 : 2'b00;
            sck_tb = clock_polarity_bit;
            peer_u.rxq.delete();
            peer_u.txq = '{16'h00d2 ^ 16'(m)};
            wr(SSP_A_CTRL, cfg(nb, m == 2, m != 0, m != 0, 1'b0, 1'b1));
            wr(SSP_A_DATA, 32'h0000_00b7 ^ 32'(m));
            repeat (4) @(posedge mclk);
            check({sck_oe, fs_oe}, 32'h0);
            #1.3 fs_tb = 1'b0;
            #250;
            repeat (8) begin
                sck_tb = !clock_polarity_bit;
                #62.5 sck_tb = clock_polarity_bit;
                #62.5;
            end
            #125 fs_tb = 1'b1;
            wait_idle();
            check(peer_got(), 32'hb7 ^ 32'(m));
            rd_chk(SSP_A_DATA, 32'h00d2 ^ 32'(m));
        end
        stop_test();
    end
endmodule
